// File: logic/pps_pkg.sv
// Constants and types of the step program sequencer and editor
package pps_pkg;
    localparam int STEP_W = 6;
    localparam int STEP_COUNT = 41;
    localparam logic [5:0] STEP_FIRST = 6'h01;
    localparam logic [5:0] STEP_MAX = 6'h29;
    localparam int WORD_W = 32;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_SELECT = 4'h4;
    localparam logic [3:0] REG_STEPDATA = 4'h8;
    localparam logic [3:0] REG_CMD = 4'hC;
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_DONE = 2;
    localparam int STS_RUN = 0;
    localparam int STS_BUSY = 1;
    localparam int STS_EDIT = 2;
    localparam int STS_OP_LSB = 3;
    localparam int STS_EXEC_LSB = 8;
    localparam int STS_SEL_LSB = 16;
    localparam int FN_LSB = 0;
    localparam int FN_MSB = 3;
    localparam int PRM_LSB = 4;
    localparam int PRM_MSB = 10;
    localparam int DIR_BIT = 11;
    localparam int RATE_LSB = 12;
    localparam int RATE_MSB = 21;
    localparam int VOL_LSB = 22;
    localparam int VOL_MSB = 31;
    localparam int OP_WINDOW_S = 2;
    localparam int CLK_HZ = 100_000_000;
    localparam int OP_WINDOW_CYC = OP_WINDOW_S * CLK_HZ;
    localparam logic [27:0] CNT_RST = 28'h0000000;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

    typedef enum logic [3:0] {
        FN_STOP = 4'h0,
        FN_RATE = 4'h1,
        FN_FILL = 4'h2,
        FN_INCR = 4'h3,
        FN_DECR = 4'h4,
        FN_GOTO_STEP = 4'h5,
        FN_EVENT = 4'h6
    } pps_fn_e;
    localparam logic [3:0] FN_LAST = 4'h6;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_NUM = 3'h1,
        ST_FUNC = 3'h2,
        ST_ARM = 3'h3,
        ST_SHIFT = 3'h4
    } pps_state_e;

    typedef enum logic [1:0] {
        EDIT_OP_SELECT_STEP = 2'h0,
        EDIT_OP_INSERT_STEP = 2'h1,
        EDIT_OP_REMOVE_STEP = 2'h2
    } pps_op_e;

    typedef enum logic [2:0] {
        DSP_VOLUME = 3'h0,
        DSP_STEP_NUMBER = 3'h1,
        DSP_FUNC = 3'h2,
        DSP_OP = 3'h3,
        DSP_BUSY = 3'h4
    } pps_disp_e;
endpackage : pps_pkg

// File: logic/pps_step_store.sv
// Step program storage, one word per step, two read ports and one write port
`timescale 1ns/1ps
module pps_step_store
    import pps_pkg::*;
(
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [5:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [5:0] rd_idx_a,
    output logic [31:0] rd_data_a,
    input wire logic [5:0] rd_idx_b,
    output logic [31:0] rd_data_b
);
    // No reset: contents must outlive a reset like retained storage
    logic [WORD_W-1:0] mem_r [1:STEP_COUNT];

    function automatic logic in_range(input logic [5:0] i);
        return (i >= STEP_FIRST) && (i <= STEP_MAX);
    endfunction : in_range

    always_ff @(posedge mclk)
    begin
        if (wr_en && in_range(wr_idx))
        begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    // Out of range reads give an all-zero stop word
    assign rd_data_a = in_range(rd_idx_a) ? mem_r[rd_idx_a] : '0;
    assign rd_data_b = in_range(rd_idx_b) ? mem_r[rd_idx_b] : '0;
endmodule : pps_step_store

// File: logic/pps_sequencer.sv
// Step program sequencer, keypad editor and register port
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
module pps_sequencer
    import pps_pkg::*;
#(
    parameter int OP_WINDOW_CYCLES = OP_WINDOW_CYC
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic key_start,
    input wire logic trig_start,
    input wire logic key_step,
    input wire logic key_func,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_opsel,
    input wire logic key_other,
    input wire logic step_done,
    output logic running,
    output logic busy,
    output logic [2:0] disp_mode,
    output logic [5:0] step_number_display,
    output logic [5:0] exec_step,
    output logic pump_on,
    output logic pump_dir,
    output logic [9:0] pump_rate,
    output logic [9:0] pump_vol
);
    localparam logic [27:0] OP_LAST = 28'(OP_WINDOW_CYCLES - 1);

    function automatic logic [5:0] clamp_step(input logic [6:0] n);
        if (n == 7'h00)
        begin
            return STEP_FIRST;
        end
        else if (n > {1'b0, STEP_MAX})
        begin
            return STEP_MAX;
        end
        return n[5:0];
    endfunction : clamp_step

    function automatic logic is_ref(input logic [31:0] w);
        return (w[FN_MSB:FN_LSB] == FN_GOTO_STEP) || (w[FN_MSB:FN_LSB] == FN_EVENT);
    endfunction : is_ref

    function automatic logic [31:0] fix_ref(input logic [31:0] w, input logic ins,
                                            input logic [5:0] s);
        logic [31:0] r;
        logic [6:0] p;
        r = w;
        p = w[PRM_MSB:PRM_LSB];
        if (is_ref(w))
        begin
            // Saturate at 41: a reference to the dropped step stays in range
            if (ins && p >= {1'b0, s} && p < {1'b0, STEP_MAX})
            begin
                r[PRM_MSB:PRM_LSB] = p + 7'h01;
            end
            else if (!ins && p > {1'b0, s})
            begin
                r[PRM_MSB:PRM_LSB] = p - 7'h01;
            end
        end
        return r;
    endfunction : fix_ref

    pps_state_e state_r, state_nxt;
    pps_op_e op_r, op_nxt;
    pps_disp_e disp_r, disp_nxt;
    logic [5:0] sel_r, sel_nxt, exec_r, exec_nxt, walk_r, walk_nxt;
    logic [27:0] cnt_r, cnt_nxt;
    logic run_r, run_nxt;
    logic [31:0] rdata_r, rd_a, rd_b, status_w, fix_w;
    logic pump_on_r, pump_dir_r;
    logic [9:0] pump_rate_r, pump_vol_r;

    wire logic cmd_wr = reg_wr && (reg_addr == REG_CMD);
    wire logic sel_wr = reg_wr && (reg_addr == REG_SELECT);
    wire logic shifting = (state_r == ST_SHIFT);
    wire logic is_ins = (op_r == EDIT_OP_INSERT_STEP);
    wire logic start_req = key_start || trig_start || (cmd_wr && reg_wdata[CMD_START]);
    wire logic stop_req = cmd_wr && reg_wdata[CMD_STOP];
    wire logic done_req = step_done || (cmd_wr && reg_wdata[CMD_DONE]);
    wire logic [3:0] cur_fn = rd_b[FN_MSB:FN_LSB];
    wire logic cur_pump = (cur_fn >= FN_RATE) && (cur_fn <= FN_DECR);
    wire logic [3:0] sel_fn = rd_a[FN_MSB:FN_LSB];

    // Walk order avoids overwriting a source before it is copied
    wire logic [5:0] src_idx = is_ins ? ((walk_r > sel_r) ? walk_r - 6'h01 : walk_r)
                                      : ((walk_r >= sel_r) ? walk_r + 6'h01 : walk_r);
    wire logic walk_done = is_ins ? (walk_r == STEP_FIRST) : (walk_r == STEP_MAX);
    wire logic [3:0] new_fn = (sel_r == STEP_FIRST) ? FN_RATE : FN_STOP;
    wire logic [31:0] shift_word = (is_ins && walk_r == sel_r) ? {28'h0000000, new_fn}
                                                               : fix_w;
    wire logic [3:0] fn_up = (sel_fn >= FN_LAST) ? FN_STOP : sel_fn + 4'h1;
    wire logic [3:0] fn_dn = (sel_fn == FN_STOP) ? FN_LAST : sel_fn - 4'h1;
    wire logic fn_we = (state_r == ST_FUNC) && (key_up || key_down);
    wire logic bus_we = reg_wr && (reg_addr == REG_STEPDATA) && !shifting;
    wire logic wr_en = shifting || fn_we || bus_we;
    wire logic [5:0] wr_idx = shifting ? walk_r : sel_r;
    wire logic [31:0] wr_data = shifting ? shift_word
                              : fn_we ? {rd_a[31:4], key_up ? fn_up : fn_dn}
                              : reg_wdata;
    wire logic [5:0] rd_idx_a = shifting ? src_idx : sel_r;
    wire logic [31:0] rd_word = (reg_addr == REG_STATUS) ? status_w
                              : (reg_addr == REG_SELECT) ? {26'h0000000, sel_r}
                              : (reg_addr == REG_STEPDATA && !shifting) ? rd_a
                              : 32'h00000000;

    assign fix_w = fix_ref(rd_a, is_ins, sel_r);

    pps_step_store u_store (
        .mclk(mclk),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_idx_a(rd_idx_a),
        .rd_data_a(rd_a),
        .rd_idx_b(exec_r),
        .rd_data_b(rd_b)
    );

    always_comb
    begin
        status_w = '0;
        status_w[STS_RUN] = run_r;
        status_w[STS_BUSY] = shifting;
        status_w[STS_EDIT] = (state_r != ST_IDLE);
        status_w[STS_OP_LSB +: 2] = op_r;
        status_w[STS_EXEC_LSB +: STEP_W] = exec_r;
        status_w[STS_SEL_LSB +: STEP_W] = sel_r;
    end

    always_comb
    begin
        run_nxt = run_r;
        exec_nxt = exec_r;
        if (start_req && !shifting)
        begin
            run_nxt = 1'b1;
            exec_nxt = STEP_FIRST;
        end
        else if (stop_req || (run_r && cur_fn == FN_STOP))
        begin
            run_nxt = 1'b0;
            exec_nxt = STEP_FIRST;
        end
        else if (run_r && cur_fn == FN_GOTO_STEP)
        begin
            exec_nxt = clamp_step(rd_b[PRM_MSB:PRM_LSB]);
        end
        else if (run_r && done_req)
        begin
            if (exec_r == STEP_MAX)
            begin
                run_nxt = 1'b0;
                exec_nxt = STEP_FIRST;
            end
            else
            begin
                exec_nxt = exec_r + 6'h01;
            end
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        op_nxt = op_r;
        disp_nxt = disp_r;
        sel_nxt = sel_r;
        walk_nxt = walk_r;
        cnt_nxt = cnt_r;
        if (sel_wr && !shifting)
        begin
            sel_nxt = clamp_step(reg_wdata[6:0]);
        end
        case (state_r)
            ST_IDLE:
            begin
                if (key_step)
                begin
                    state_nxt = ST_NUM;
                    disp_nxt = DSP_STEP_NUMBER;
                end
            end
            ST_NUM:
            begin
                if (key_up)
                begin
                    sel_nxt = (sel_r == STEP_MAX) ? STEP_MAX : sel_r + 6'h01;
                end
                else if (key_down)
                begin
                    sel_nxt = (sel_r == STEP_FIRST) ? STEP_FIRST : sel_r - 6'h01;
                end
                else if (key_func)
                begin
                    state_nxt = ST_FUNC;
                    disp_nxt = DSP_FUNC;
                end
                else if (key_opsel)
                begin
                    op_nxt = EDIT_OP_INSERT_STEP;
                    state_nxt = ST_ARM;
                    disp_nxt = DSP_OP;
                    cnt_nxt = CNT_RST;
                end
                else if (key_other)
                begin
                    state_nxt = ST_IDLE;
                    disp_nxt = DSP_VOLUME;
                end
            end
            ST_FUNC:
            begin
                if (key_func)
                begin
                    state_nxt = ST_IDLE;
                    disp_nxt = DSP_VOLUME;
                end
                else if (key_step)
                begin
                    state_nxt = ST_NUM;
                    disp_nxt = DSP_STEP_NUMBER;
                end
            end
            ST_ARM:
            begin
                if (key_opsel)
                begin
                    cnt_nxt = CNT_RST;
                    if (op_r == EDIT_OP_INSERT_STEP)
                    begin
                        op_nxt = EDIT_OP_REMOVE_STEP;
                    end
                    else
                    begin
                        op_nxt = EDIT_OP_SELECT_STEP;
                        state_nxt = ST_NUM;
                        disp_nxt = DSP_STEP_NUMBER;
                    end
                end
                else if (key_step && !run_r)
                begin
                    state_nxt = ST_SHIFT;
                    disp_nxt = DSP_BUSY;
                    walk_nxt = is_ins ? STEP_MAX : STEP_FIRST;
                end
                else if (key_step || key_up || key_down || key_func || key_other
                         || cnt_r == OP_LAST)
                begin
                    op_nxt = EDIT_OP_SELECT_STEP;
                    state_nxt = ST_NUM;
                    disp_nxt = DSP_STEP_NUMBER;
                end
                else
                begin
                    cnt_nxt = cnt_r + 28'h0000001;
                end
            end
            ST_SHIFT:
            begin
                if (walk_done)
                begin
                    op_nxt = EDIT_OP_SELECT_STEP;
                    state_nxt = ST_NUM;
                    disp_nxt = DSP_STEP_NUMBER;
                end
                else
                begin
                    walk_nxt = is_ins ? walk_r - 6'h01 : walk_r + 6'h01;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
                disp_nxt = DSP_VOLUME;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= ST_IDLE;
            op_r <= EDIT_OP_SELECT_STEP;
            disp_r <= DSP_VOLUME;
            sel_r <= STEP_FIRST;
            exec_r <= STEP_FIRST;
            walk_r <= STEP_FIRST;
            cnt_r <= CNT_RST;
            run_r <= 1'b0;
            rdata_r <= RDATA_RST;
        end
        else
        begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            disp_r <= disp_nxt;
            sel_r <= sel_nxt;
            exec_r <= exec_nxt;
            walk_r <= walk_nxt;
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            rdata_r <= reg_rd ? rd_word : RDATA_RST;
        end
    end

    // Pump setup follows the executing step one cycle later
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pump_on_r <= 1'b0;
            pump_dir_r <= 1'b0;
            pump_rate_r <= 10'h000;
            pump_vol_r <= 10'h000;
        end
        else
        begin
            pump_on_r <= run_r && cur_pump;
            pump_dir_r <= rd_b[DIR_BIT];
            pump_rate_r <= rd_b[RATE_MSB:RATE_LSB];
            pump_vol_r <= rd_b[VOL_MSB:VOL_LSB];
        end
    end

    assign reg_rdata = rdata_r;
    assign running = run_r;
    assign busy = shifting;
    assign disp_mode = disp_r;
    assign step_number_display = sel_r;
    assign exec_step = exec_r;
    assign pump_on = pump_on_r;
    assign pump_dir = pump_dir_r;
    assign pump_rate = pump_rate_r;
    assign pump_vol = pump_vol_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_arm_go;
        state_r == ST_ARM && !key_opsel && key_step && !run_r;
    endsequence
    sequence s_busy_hold;
        busy [*8];
    endsequence

    property p_start;
        start_req && !shifting |=> run_r && exec_r == STEP_FIRST;
    endproperty
    a_start: assert property (p_start) else $error("start did not begin at step 1");
    property p_adv;
        run_r && done_req && cur_pump && !start_req && !stop_req && exec_r != STEP_MAX
            |=> exec_r == $past(exec_r) + 6'h01;
    endproperty
    a_adv: assert property (p_adv) else $error("step did not advance by one");
    property p_sat;
        state_r == ST_NUM && key_up && sel_r == STEP_MAX |=> sel_r == STEP_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("selection passed step 41");
    property p_selwr;
        sel_wr && !shifting && !(state_r == ST_NUM && (key_up || key_down))
            |=> sel_r == clamp_step($past(reg_wdata[6:0]));
    endproperty
    a_selwr: assert property (p_selwr) else $error("selection write lost");
    property p_fn;
        fn_we |-> wr_en && wr_idx == sel_r && wr_data[FN_MSB:FN_LSB] != sel_fn;
    endproperty
    a_fn: assert property (p_fn) else $error("function code not cycled");
    property p_exit;
        state_r == ST_FUNC && key_func |=> state_r == ST_IDLE && disp_mode == DSP_VOLUME;
    endproperty
    a_exit: assert property (p_exit) else $error("function key did not leave edit");
    property p_cancel;
        state_r == ST_ARM && key_other && !key_opsel && !key_step
            |=> state_r == ST_NUM && op_r == EDIT_OP_SELECT_STEP;
    endproperty
    a_cancel: assert property (p_cancel) else $error("edit operation not cancelled");
    property p_busy;
        s_arm_go |=> s_busy_hold ##34 !busy && state_r == ST_NUM;
    endproperty
    a_busy: assert property (p_busy) else $error("busy span wrong");
    property p_insdef;
        shifting && is_ins && walk_r == sel_r
            |-> wr_data == ((sel_r == STEP_FIRST) ? 32'(FN_RATE) : 32'(FN_STOP));
    endproperty
    a_insdef: assert property (p_insdef) else $error("inserted step default wrong");
    property p_ref;
        shifting && !is_ins && is_ref(rd_a) && rd_a[PRM_MSB:PRM_LSB] > {1'b0, sel_r}
            |-> wr_data[PRM_MSB:PRM_LSB] == rd_a[PRM_MSB:PRM_LSB] - 7'h01;
    endproperty
    a_ref: assert property (p_ref) else $error("reference not lowered");
    property p_stop;
        run_r && cur_fn == FN_STOP && !start_req |=> !run_r && exec_r == STEP_FIRST;
    endproperty
    a_stop: assert property (p_stop) else $error("stop step did not halt");
    property p_jump;
        run_r && cur_fn == FN_GOTO_STEP && !start_req && !stop_req
            |=> exec_r == clamp_step($past(rd_b[PRM_MSB:PRM_LSB]));
    endproperty
    a_jump: assert property (p_jump) else $error("goto target not taken");
endmodule : pps_sequencer

// File: test/pps_engine_model.sv
// Pump engine stand-in that reports step completion
`timescale 1ns/1ps
module pps_engine_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic pump_on,
    input wire logic [3:0] dly,
    output logic step_done
);
    logic [3:0] cnt_r;
    // Completion only while pumping; dly sets prompt or slow answers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= 4'h0;
            step_done <= 1'b0;
        end
        else
        begin
            step_done <= pump_on && (cnt_r == dly);
            cnt_r <= (!pump_on || cnt_r == dly) ? 4'h0 : cnt_r + 4'h1;
        end
    end
endmodule : pps_engine_model

// File: test/pps_sequencer_tb_top.sv
// Self-checking bench of the step program sequencer
`timescale 1ns/1ps
module pps_sequencer_tb_top;
    import pps_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [7:0] k = 8'h00;
    logic [3:0] dly = 4'h2;
    logic step_done, running, busy, pump_on, pump_dir;
    logic [2:0] disp_mode;
    logic [5:0] step_number_display, exec_step;
    logic [9:0] pump_rate, pump_vol;
    logic [31:0] reg_rdata;
    logic [31:0] w [1:41];
    logic [31:0] q [$];
    logic seen3 = 1'b0;
    logic seen4 = 1'b0;
    int bad_count = 0;
    int n_checks = 0;

    pps_sequencer #(.OP_WINDOW_CYCLES(20)) pps_sequencer_inst (.mclk(mclk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .key_start(k[0]), .trig_start(k[1]), .key_step(k[2]),
        .key_func(k[3]), .key_up(k[4]), .key_down(k[5]), .key_opsel(k[6]), .key_other(k[7]),
        .step_done(step_done), .running(running), .busy(busy), .disp_mode(disp_mode),
        .step_number_display(step_number_display), .exec_step(exec_step), .pump_on(pump_on),
        .pump_dir(pump_dir), .pump_rate(pump_rate), .pump_vol(pump_vol));
    pps_engine_model pps_engine_model_inst (.mclk(mclk), .arst_n(arst_n), .pump_on(pump_on),
        .dly(dly), .step_done(step_done));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    function automatic logic [31:0] sts(logic r, logic e, logic [1:0] op, logic [5:0] ex,
                                        logic [5:0] sel);
        sts = {10'h000, sel, 2'h0, ex, 3'h0, op, e, 1'b0, r};
    endfunction : sts

    function automatic logic [31:0] gw(logic [6:0] p);
        gw = {21'h000000, p, 4'h5};
    endfunction : gw

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // Expected word queued; the monitor below compares it
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        q.push_back(e);
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic key(input int i);
        @(posedge mclk);
        k[i] <= 1'b1;
        @(posedge mclk);
        k <= 8'h00;
    endtask : key

    // Bounded wait for busy (b=1) or running (b=0) to drop
    task automatic wt(input bit b);
        int n;
        n = 0;
        while ((b ? busy : running) !== 1'b0 && n < 200)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 200)
            chk(32'h1, 32'h0);
    endtask : wt

    task automatic shift(input logic [5:0] s, input int ops);
        wr(REG_SELECT, 32'(s));
        repeat (ops) key(6);
        key(2);
        #1 chk(32'({busy, disp_mode}), 32'h0C);
        key(0);
        #1 chk(32'(running), 32'h0);
        wt(1'b1);
    endtask : shift

    always @(posedge mclk)
    begin
        rd_d <= reg_rd;
        if (rd_d)
            chk(reg_rdata, q.pop_front());
        if (running === 1'b1 && exec_step === 6'h03)
            seen3 <= 1'b1;
        if (running === 1'b1 && exec_step === 6'h04)
            seen4 <= 1'b1;
    end

    // Whole run needs several hundred cycles
    initial
    begin
        #200000;
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(32'h3a02bc37));
        for (int i = 1; i <= 41; i++)
            w[i] = 32'h0;
        w[1] = ($urandom() & 32'hFFFFF800) | 32'h1;
        w[3] = ($urandom() & 32'hFFFFF800) | 32'h1;
        w[4] = ($urandom() & 32'hFFFFF800) | 32'h1;
        w[2] = gw(7'h04);
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 1; i <= 41; i++)
        begin
            wr(REG_SELECT, 32'(i));
            wr(REG_STEPDATA, w[i]);
        end
        wr(REG_SELECT, 32'h32);
        rd(REG_SELECT, 32'h29);
        wr(REG_SELECT, 32'h0);
        rd(REG_SELECT, 32'h1);
        wr(REG_SELECT, 32'h3);
        rd(REG_STEPDATA, w[3]);
        rd(4'h6, 32'h0);
        for (int s = 0; s < 3; s++)
        begin
            dly <= 4'(2 + 4 * s);
            seen3 = 1'b0;
            seen4 = 1'b0;
            if (s == 2)
                wr(REG_CMD, 32'h1);
            else
                key(s);
            #1 chk(32'({running, exec_step}), 32'h41);
            @(posedge mclk);
            #1 chk(32'({pump_on, pump_rate}), 32'({1'b1, w[1][21:12]}));
            chk(32'({pump_vol, pump_dir}), 32'({w[1][31:22], w[1][11]}));
            wt(1'b0);
            chk(32'({seen3, seen4}), 32'h1);
            rd(REG_STATUS, sts(1'b0, 1'b0, 2'h0, 6'h01, 6'h03));
        end
        // Slow engine so only the bus command completes the step
        dly <= 4'hF;
        key(0);
        wr(REG_CMD, 32'h4);
        #1 chk(32'({running, exec_step}), 32'h42);
        wr(REG_CMD, 32'h2);
        #1 chk(32'({running, exec_step}), 32'h01);
        wr(REG_SELECT, 32'h6);
        key(2);
        key(3);
        key(4);
        rd(REG_STEPDATA, 32'h1);
        key(5);
        key(5);
        rd(REG_STEPDATA, 32'h6);
        key(3);
        #1 chk(32'(disp_mode), 32'h0);
        rd(REG_STATUS, sts(1'b0, 1'b0, 2'h0, 6'h01, 6'h06));
        wr(REG_STEPDATA, 32'h0);
        key(2);
        for (int i = 1; i <= 3; i++)
        begin
            key(6);
            rd(REG_STATUS, sts(1'b0, 1'b1, 2'(i % 3), 6'h01, 6'h06));
        end
        shift(6'h02, 1);
        rd(REG_STEPDATA, 32'h0);
        wr(REG_SELECT, 32'h3);
        rd(REG_STEPDATA, gw(7'h05));
        wr(REG_SELECT, 32'h5);
        rd(REG_STEPDATA, w[4]);
        shift(6'h02, 2);
        rd(REG_STEPDATA, gw(7'h04));
        wr(REG_SELECT, 32'h4);
        rd(REG_STEPDATA, w[4]);
        shift(6'h01, 1);
        rd(REG_STEPDATA, 32'h1);
        wr(REG_SELECT, 32'h3);
        rd(REG_STEPDATA, gw(7'h05));
        wr(REG_SELECT, 32'h29);
        key(4);
        #1 chk(32'(step_number_display), 32'h29);
        rd(REG_SELECT, 32'h29);
        key(6);
        repeat (25) @(posedge mclk);
        rd(REG_STATUS, sts(1'b0, 1'b1, 2'h0, 6'h01, 6'h29));
        key(6);
        key(7);
        rd(REG_STATUS, sts(1'b0, 1'b1, 2'h0, 6'h01, 6'h29));
        repeat (3) @(posedge mclk);
        report_and_stop();
    end
endmodule : pps_sequencer_tb_top
